// ===== core/etor_defines.svh
`ifndef ETOR_DEFINES_SVH
`define ETOR_DEFINES_SVH

// Register addresses on the serial control port.
`define ETOR_ADDR_CAL_OPT      8'h34
`define ETOR_ADDR_DIG_TEST     8'h35
`define ETOR_ADDR_ANA_PLL      8'h36
`define ETOR_ADDR_REG_FORCE    8'h37

// Reset values: every bit of the bank clears at power-up.
`define ETOR_RST_CAL_OPT       8'h00
`define ETOR_RST_DIG_TEST      8'h00
`define ETOR_RST_ANA_PLL       8'h00
`define ETOR_RST_REG_FORCE     8'h00
`define ETOR_RDATA_UNMAPPED    8'h00

// Calibration option fields; bits 7 to 4 are unused and read as zero.
`define ETOR_CAL_USED_MASK     8'h0f
`define ETOR_CAL_BUF_PATH      3
`define ETOR_CAL_OVR_MODE      2
`define ETOR_CAL_LTD_PHASE     1
`define ETOR_CAL_HOLD_PLL      0

// Digital test select fields.
`define ETOR_DT_MULTITONE      7
`define ETOR_DT_DIG_SEL_HI     6
`define ETOR_DT_DIG_SEL_LO     4
`define ETOR_DT_RX_SEL_HI      3
`define ETOR_DT_RX_SEL_LO      0

// Analogue and PLL test fields.
`define ETOR_AP_IF_LOW_SUPPLY  7
`define ETOR_AP_ANA_SEL_HI     6
`define ETOR_AP_ANA_SEL_LO     4
`define ETOR_AP_DIG_REG_OFF    3
`define ETOR_AP_PLL_CTRL_HI    2
`define ETOR_AP_PLL_CTRL_LO    1
`define ETOR_AP_OSC_TEST       0

// Regulator and status force fields.
`define ETOR_RF_OSC_REG_ON     7
`define ETOR_RF_PLL_REG_ON     6
`define ETOR_RF_AMP_REG_ON     5
`define ETOR_RF_OSC_RDY        4
`define ETOR_RF_PLL_RDY        3
`define ETOR_RF_AMP_RDY        2
`define ETOR_RF_LOCK           1
`define ETOR_RF_XTAL_RDY       0

`endif

// ===== core/etor_pkg.sv
package etor_pkg;

  // One byte-wide register of the bank.
  typedef logic [7:0] etor_byte_t;

  // Which register an access addresses.
  typedef enum logic [2:0] {
    ETOR_SEL_NONE  = 3'b000,
    ETOR_SEL_CAL   = 3'b001,
    ETOR_SEL_DIG   = 3'b010,
    ETOR_SEL_ANA   = 3'b011,
    ETOR_SEL_FORCE = 3'b100
  } etor_sel_e;

endpackage : etor_pkg

// ===== core/etor_regs.sv
// Function
// - With override mode clear, each regulator test bit is ORed onto that regulator's normal line.
// - With override mode set, each regulator test bit replaces that regulator's normal line.
// - With the protect bit set, a PLL start-up request waits until timer calibration has ended.
// - With the limited trim bit set, some phase-trim values are left out of the image search.
// - The buffer calibration bit switches the calibration path on while the buffer is trimmed.
// - Every bit of the bank is zero after power-up.
// - Bits 7, 6 and 5 of the force register switch on the oscillator, PLL and amplifier regulators.
// - Bits 4 to 0 of the force register override oscillator, PLL, amplifier, lock and crystal ready.
// - Bits 6 to 4 of the digital test register pick the digital probe with the pin settings.
// - Bits 3 to 0 of the digital test register pick an extra receive debug probe.
// - Bit 7 of the digital test register enables multi-tone channel filter testing.
// - Bits 6 to 4 of the analogue test register pick the analogue probe.
// - Bit 3 of the analogue test register switches the digital regulator off.
// - Bits 2 to 1 drive the PLL test controls and bit 0 enables oscillator test mode.
`timescale 1ns/1ps
`default_nettype none
`include "etor_defines.svh"

module etor_regs
  import etor_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  input  wire logic       osc_reg_normal,
  input  wire logic       pll_reg_normal,
  input  wire logic       amp_reg_normal,
  output var  logic       osc_reg_en,
  output var  logic       pll_reg_en,
  output var  logic       amp_reg_en,
  input  wire logic       osc_ready_raw,
  input  wire logic       pll_ready_raw,
  input  wire logic       amp_ready_raw,
  input  wire logic       pll_lock_raw,
  input  wire logic       crystal_ready_raw,
  output var  logic       osc_ready_seen,
  output var  logic       pll_ready_seen,
  output var  logic       amp_ready_seen,
  output var  logic       pll_lock_seen,
  output var  logic       crystal_ready_seen,
  input  wire logic       pll_start_req,
  input  wire logic       timer_cal_busy,
  output var  logic       pll_start_go,
  output var  logic       buffer_cal_path_on,
  output var  logic       limited_phase_trim,
  output var  logic       filter_multitone_test,
  output var  logic [2:0] digital_probe_select,
  output var  logic [3:0] rx_debug_probe_select,
  output var  logic       if_probe_low_supply,
  output var  logic [2:0] analog_probe_select,
  output var  logic       digital_regulator_off,
  output var  logic [1:0] pll_test_ctrl,
  output var  logic       oscillator_test_enable
);

  //////////////////////////////////////////////////////////////////////////////

  // Regulator line as seen by the analogue side for one test bit.
  function automatic logic reg_line(input logic mode, input logic tbit, input logic normal);
    reg_line = mode ? tbit : (tbit | normal);
  endfunction : reg_line

  // Status line as seen by the sequencer; a force bit can only make it true.
  function automatic logic force_line(input logic force_bit, input logic raw);
    force_line = force_bit | raw;
  endfunction : force_line

  //////////////////////////////////////////////////////////////////////////////

  etor_byte_t cal_opt_r;
  etor_byte_t dig_test_r;
  etor_byte_t ana_pll_r;
  etor_byte_t reg_force_r;
  etor_byte_t cal_opt_nxt;
  etor_byte_t rdata_nxt;
  etor_sel_e  sel;
  logic       osc_reg_nxt;
  logic       pll_reg_nxt;
  logic       amp_reg_nxt;
  logic       pll_go_nxt;
  logic       ovr_mode;
  logic       hold_pll;

  // Address decode; anything outside the four bytes selects nothing.
  assign sel = (reg_addr == `ETOR_ADDR_CAL_OPT)   ? ETOR_SEL_CAL   :
               (reg_addr == `ETOR_ADDR_DIG_TEST)  ? ETOR_SEL_DIG   :
               (reg_addr == `ETOR_ADDR_ANA_PLL)   ? ETOR_SEL_ANA   :
               (reg_addr == `ETOR_ADDR_REG_FORCE) ? ETOR_SEL_FORCE : ETOR_SEL_NONE;

  // The unused upper nibble is dropped on write so it can never read back as one.
  assign cal_opt_nxt = reg_wdata & `ETOR_CAL_USED_MASK;

  // Read mux; unmapped addresses return zero rather than stale data.
  assign rdata_nxt = (sel == ETOR_SEL_CAL)   ? cal_opt_r   :
                     (sel == ETOR_SEL_DIG)   ? dig_test_r  :
                     (sel == ETOR_SEL_ANA)   ? ana_pll_r   :
                     (sel == ETOR_SEL_FORCE) ? reg_force_r : `ETOR_RDATA_UNMAPPED;

  //////////////////////////////////////////////////////////////////////////////

  // Register writes; power-up clears the whole bank.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cal_opt_r   <= `ETOR_RST_CAL_OPT;
      dig_test_r  <= `ETOR_RST_DIG_TEST;
      ana_pll_r   <= `ETOR_RST_ANA_PLL;
      reg_force_r <= `ETOR_RST_REG_FORCE;
    end else if (reg_wr) begin
      if (sel == ETOR_SEL_CAL) cal_opt_r <= cal_opt_nxt;
      if (sel == ETOR_SEL_DIG) dig_test_r <= reg_wdata;
      if (sel == ETOR_SEL_ANA) ana_pll_r <= reg_wdata;
      if (sel == ETOR_SEL_FORCE) reg_force_r <= reg_wdata;
    end
  end

  // Read data is registered and holds until the next read.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata <= `ETOR_RDATA_UNMAPPED;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  assign ovr_mode = cal_opt_r[`ETOR_CAL_OVR_MODE];
  assign hold_pll = cal_opt_r[`ETOR_CAL_HOLD_PLL];

  // Regulator enables. Replace mode can turn a regulator off, which is why
  // it sits behind its own mode bit and defaults to the harmless OR form.
  assign osc_reg_nxt = reg_line(ovr_mode, reg_force_r[`ETOR_RF_OSC_REG_ON], osc_reg_normal);
  assign pll_reg_nxt = reg_line(ovr_mode, reg_force_r[`ETOR_RF_PLL_REG_ON], pll_reg_normal);
  assign amp_reg_nxt = reg_line(ovr_mode, reg_force_r[`ETOR_RF_AMP_REG_ON], amp_reg_normal);

  // PLL start gate: a pending request is held back while timer calibration runs.
  assign pll_go_nxt = pll_start_req & ~(hold_pll & timer_cal_busy);

  // Control outputs are registered, costing one cycle of latency on each path.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      osc_reg_en         <= 1'b0;
      pll_reg_en         <= 1'b0;
      amp_reg_en         <= 1'b0;
      osc_ready_seen     <= 1'b0;
      pll_ready_seen     <= 1'b0;
      amp_ready_seen     <= 1'b0;
      pll_lock_seen      <= 1'b0;
      crystal_ready_seen <= 1'b0;
      pll_start_go       <= 1'b0;
    end else begin
      osc_reg_en         <= osc_reg_nxt;
      pll_reg_en         <= pll_reg_nxt;
      amp_reg_en         <= amp_reg_nxt;
      osc_ready_seen     <= force_line(reg_force_r[`ETOR_RF_OSC_RDY], osc_ready_raw);
      pll_ready_seen     <= force_line(reg_force_r[`ETOR_RF_PLL_RDY], pll_ready_raw);
      amp_ready_seen     <= force_line(reg_force_r[`ETOR_RF_AMP_RDY], amp_ready_raw);
      pll_lock_seen      <= force_line(reg_force_r[`ETOR_RF_LOCK], pll_lock_raw);
      crystal_ready_seen <= force_line(reg_force_r[`ETOR_RF_XTAL_RDY], crystal_ready_raw);
      pll_start_go       <= pll_go_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // Field outputs are slices of the register flip-flops themselves.
  assign buffer_cal_path_on     = cal_opt_r[`ETOR_CAL_BUF_PATH];
  assign limited_phase_trim     = cal_opt_r[`ETOR_CAL_LTD_PHASE];
  assign filter_multitone_test  = dig_test_r[`ETOR_DT_MULTITONE];
  assign digital_probe_select   = dig_test_r[`ETOR_DT_DIG_SEL_HI:`ETOR_DT_DIG_SEL_LO];
  assign rx_debug_probe_select  = dig_test_r[`ETOR_DT_RX_SEL_HI:`ETOR_DT_RX_SEL_LO];
  assign if_probe_low_supply    = ana_pll_r[`ETOR_AP_IF_LOW_SUPPLY];
  assign analog_probe_select    = ana_pll_r[`ETOR_AP_ANA_SEL_HI:`ETOR_AP_ANA_SEL_LO];
  assign digital_regulator_off  = ana_pll_r[`ETOR_AP_DIG_REG_OFF];
  assign pll_test_ctrl          = ana_pll_r[`ETOR_AP_PLL_CTRL_HI:`ETOR_AP_PLL_CTRL_LO];
  assign oscillator_test_enable = ana_pll_r[`ETOR_AP_OSC_TEST];

  //////////////////////////////////////////////////////////////////////////////

  // Checks on the bank and on the derived control lines.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  // The OR form never turns a regulator off that its normal line wants on.
  or_mode_reg_a: assert property (
    !ovr_mode && osc_reg_normal |=> osc_reg_en)
    else $error("Oscillator regulator dropped while normal line was high in OR mode.");

  // Replace mode follows the test bit whatever the normal line says.
  replace_mode_reg_a: assert property (
    ovr_mode |=> amp_reg_en == $past(reg_force_r[`ETOR_RF_AMP_REG_ON]))
    else $error("Amplifier regulator does not follow its test bit in replace mode.");

  // The PLL regulator test bit forces the line on in either mode.
  pll_reg_bit_a: assert property (
    reg_force_r[`ETOR_RF_PLL_REG_ON] |=> pll_reg_en)
    else $error("PLL regulator not enabled while its test bit is set.");

  // No PLL start leaves the gate while protection holds it off.
  pll_hold_off_a: assert property (
    hold_pll && timer_cal_busy |=> !pll_start_go)
    else $error("PLL start passed during timer calibration with protection set.");

  // Without protection the request passes straight through one cycle later.
  pll_pass_a: assert property (
    !hold_pll && pll_start_req |=> pll_start_go)
    else $error("PLL start request blocked with protection clear.");

  // A set force bit makes the sequencer see lock however the PLL reports.
  force_lock_a: assert property (
    reg_force_r[`ETOR_RF_LOCK] |=> pll_lock_seen)
    else $error("Lock force bit did not reach the sequencer.");

  // With a force bit clear the real crystal status comes through untouched.
  xtal_follow_a: assert property (
    !reg_force_r[`ETOR_RF_XTAL_RDY] |=> crystal_ready_seen == $past(crystal_ready_raw))
    else $error("Crystal ready seen differs from raw status without force.");

  // A write to the calibration register reads back with the upper nibble cleared.
  cal_readback_a: assert property (
    reg_wr && sel == ETOR_SEL_CAL ##1 reg_rd && !reg_wr && reg_addr == `ETOR_ADDR_CAL_OPT
    |=> reg_rdata == ($past(reg_wdata, 2) & `ETOR_CAL_USED_MASK))
    else $error("Calibration register read back the wrong value.");

  // The unused bits of the calibration register never hold a one.
  cal_upper_zero_a: assert property (
    cal_opt_r[7:4] == 4'h0)
    else $error("Unused calibration bits became set.");

  // A full-byte register keeps a written value until the next write to it.
  dig_hold_a: assert property (
    !(reg_wr && sel == ETOR_SEL_DIG) |=> dig_test_r == $past(dig_test_r))
    else $error("Digital test register changed without a write.");

  // Unmapped addresses read as zero.
  unmapped_read_a: assert property (
    reg_rd && sel == ETOR_SEL_NONE |=> reg_rdata == `ETOR_RDATA_UNMAPPED)
    else $error("Unmapped read returned nonzero data.");

  // Reset leaves the whole bank clear on the following edge.
  reset_clear_a: assert property (@(posedge ref_clk) disable iff (1'b0)
    srst |=> (cal_opt_r | dig_test_r | ana_pll_r | reg_force_r) == 8'h00)
    else $error("Register bank not cleared by reset.");

  // In OR form the oscillator line is exactly its test bit or its normal line.
  or_form_osc_a: assert property (
    !ovr_mode |=> osc_reg_en == $past(reg_force_r[`ETOR_RF_OSC_REG_ON] | osc_reg_normal))
    else $error("Oscillator regulator is not the OR of test bit and normal line.");

  // The same OR form holds for the PLL regulator.
  or_form_pll_a: assert property (
    !ovr_mode |=> pll_reg_en == $past(reg_force_r[`ETOR_RF_PLL_REG_ON] | pll_reg_normal))
    else $error("PLL regulator is not the OR of test bit and normal line.");

  // The same OR form holds for the amplifier regulator.
  or_form_amp_a: assert property (
    !ovr_mode |=> amp_reg_en == $past(reg_force_r[`ETOR_RF_AMP_REG_ON] | amp_reg_normal))
    else $error("Amplifier regulator is not the OR of test bit and normal line.");

  // Replace mode may switch the oscillator regulator off against the sequencer.
  replace_osc_a: assert property (
    ovr_mode |=> osc_reg_en == $past(reg_force_r[`ETOR_RF_OSC_REG_ON]))
    else $error("Oscillator regulator does not follow its test bit in replace mode.");

  // Replace mode hands the PLL regulator to its test bit alone.
  replace_pll_a: assert property (
    ovr_mode |=> pll_reg_en == $past(reg_force_r[`ETOR_RF_PLL_REG_ON]))
    else $error("PLL regulator does not follow its test bit in replace mode.");

  // The oscillator regulator test bit forces the line on in either mode.
  osc_reg_bit_a: assert property (
    reg_force_r[`ETOR_RF_OSC_REG_ON] |=> osc_reg_en)
    else $error("Oscillator regulator not enabled while its test bit is set.");

  // A forced oscillator ready lets the sequence run past a failing oscillator.
  force_osc_rdy_a: assert property (
    reg_force_r[`ETOR_RF_OSC_RDY] |=> osc_ready_seen)
    else $error("Oscillator ready force bit did not reach the sequencer.");

  // A forced PLL ready reaches the sequencer.
  force_pll_rdy_a: assert property (
    reg_force_r[`ETOR_RF_PLL_RDY] |=> pll_ready_seen)
    else $error("PLL ready force bit did not reach the sequencer.");

  // A forced amplifier ready reaches the sequencer.
  force_amp_rdy_a: assert property (
    reg_force_r[`ETOR_RF_AMP_RDY] |=> amp_ready_seen)
    else $error("Amplifier ready force bit did not reach the sequencer.");

  // Without its force bit the lock status is the real detector output.
  lock_follow_a: assert property (
    !reg_force_r[`ETOR_RF_LOCK] |=> pll_lock_seen == $past(pll_lock_raw))
    else $error("Lock seen differs from raw lock without force.");

  // A write to the calibration byte sets the limited trim output.
  ltd_trim_a: assert property (
    reg_wr && sel == ETOR_SEL_CAL |=>
      limited_phase_trim == $past(reg_wdata[`ETOR_CAL_LTD_PHASE]))
    else $error("Limited phase trim does not follow the written bit.");

  // A write to the calibration byte sets the buffer calibration path.
  buf_path_a: assert property (
    reg_wr && sel == ETOR_SEL_CAL |=>
      buffer_cal_path_on == $past(reg_wdata[`ETOR_CAL_BUF_PATH]))
    else $error("Buffer calibration path does not follow the written bit.");

  // The digital probe field follows a write to the digital test byte.
  dig_probe_a: assert property (
    reg_wr && sel == ETOR_SEL_DIG |=>
      digital_probe_select == $past(reg_wdata[`ETOR_DT_DIG_SEL_HI:`ETOR_DT_DIG_SEL_LO]))
    else $error("Digital probe select does not follow the written field.");

  // The receive debug field follows a write to the digital test byte.
  rx_probe_a: assert property (
    reg_wr && sel == ETOR_SEL_DIG |=>
      rx_debug_probe_select == $past(reg_wdata[`ETOR_DT_RX_SEL_HI:`ETOR_DT_RX_SEL_LO]))
    else $error("Receive debug select does not follow the written field.");

  // The multi-tone filter test bit follows a write to the digital test byte.
  multitone_bit_a: assert property (
    reg_wr && sel == ETOR_SEL_DIG |=>
      filter_multitone_test == $past(reg_wdata[`ETOR_DT_MULTITONE]))
    else $error("Multi-tone test enable does not follow the written bit.");

  // The analogue probe field follows a write to the analogue test byte.
  ana_probe_a: assert property (
    reg_wr && sel == ETOR_SEL_ANA |=>
      analog_probe_select == $past(reg_wdata[`ETOR_AP_ANA_SEL_HI:`ETOR_AP_ANA_SEL_LO]))
    else $error("Analogue probe select does not follow the written field.");

  // The digital regulator disable follows its bit; setting it starves the core.
  dig_reg_off_a: assert property (
    reg_wr && sel == ETOR_SEL_ANA |=>
      digital_regulator_off == $past(reg_wdata[`ETOR_AP_DIG_REG_OFF]))
    else $error("Digital regulator disable does not follow the written bit.");

  // The PLL test controls follow a write to the analogue test byte.
  pll_ctrl_a: assert property (
    reg_wr && sel == ETOR_SEL_ANA |=>
      pll_test_ctrl == $past(reg_wdata[`ETOR_AP_PLL_CTRL_HI:`ETOR_AP_PLL_CTRL_LO]))
    else $error("PLL test controls do not follow the written field.");

  // Main scenarios worth seeing in simulation.
  replace_off_c: cover property (ovr_mode && osc_reg_normal ##1 !osc_reg_en);
  pll_held_c:    cover property (hold_pll && timer_cal_busy && pll_start_req ##1 !timer_cal_busy);
  forced_rdy_c:  cover property (reg_force_r[`ETOR_RF_OSC_RDY] && !osc_ready_raw);
  write_read_c:  cover property (reg_wr && sel == ETOR_SEL_ANA ##1 reg_rd && sel == ETOR_SEL_ANA);

endmodule : etor_regs

`default_nettype wire

// ===== tb/etor_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none

module etor_regs_tb
  import etor_pkg::*;
;
  typedef struct {string name; int unsigned what; etor_byte_t exp;} etor_note_s;

  logic       ref_clk, srst, reg_wr, reg_rd, look_req, result_due;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       osc_reg_normal, pll_reg_normal, amp_reg_normal, osc_reg_en, pll_reg_en, amp_reg_en;
  logic       osc_ready_raw, pll_ready_raw, amp_ready_raw, pll_lock_raw, crystal_ready_raw;
  logic       osc_ready_seen, pll_ready_seen, amp_ready_seen, pll_lock_seen, crystal_ready_seen;
  logic       pll_start_req, timer_cal_busy, pll_start_go, buffer_cal_path_on, limited_phase_trim;
  logic       filter_multitone_test, if_probe_low_supply, digital_regulator_off;
  logic       oscillator_test_enable;
  logic [2:0] digital_probe_select, analog_probe_select;
  logic [3:0] rx_debug_probe_select;
  logic [1:0] pll_test_ctrl;
  etor_note_s notes[$];
  int         n_fail = 0;
  int         checked = 0;
  int         cycles = 0;

  etor_regs dut (
    .ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .osc_reg_normal, .pll_reg_normal, .amp_reg_normal, .osc_reg_en, .pll_reg_en, .amp_reg_en,
    .osc_ready_raw, .pll_ready_raw, .amp_ready_raw, .pll_lock_raw, .crystal_ready_raw,
    .osc_ready_seen, .pll_ready_seen, .amp_ready_seen, .pll_lock_seen, .crystal_ready_seen,
    .pll_start_req, .timer_cal_busy, .pll_start_go, .buffer_cal_path_on, .limited_phase_trim,
    .filter_multitone_test, .digital_probe_select, .rx_debug_probe_select, .if_probe_low_supply,
    .analog_probe_select, .digital_regulator_off, .pll_test_ctrl, .oscillator_test_enable
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 10 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Output groups packed as bytes so one compare path serves every check.
  function automatic etor_byte_t obs(input int unsigned what);
    case (what)
      1: obs = {5'h00, osc_reg_en, pll_reg_en, amp_reg_en};
      2: obs = {3'h0, osc_ready_seen, pll_ready_seen, amp_ready_seen, pll_lock_seen,
                crystal_ready_seen};
      3: obs = {7'h00, pll_start_go};
      4: obs = {4'h0, buffer_cal_path_on, 1'b0, limited_phase_trim, 1'b0};
      5: obs = {filter_multitone_test, digital_probe_select, rx_debug_probe_select};
      6: obs = {if_probe_low_supply, analog_probe_select, digital_regulator_off, pll_test_ctrl,
                oscillator_test_enable};
      default: obs = reg_rdata;
    endcase
  endfunction : obs

  ////////////////////////////////////////////////////////////////////////////////
  // Driver tasks; each leaves a free cycle so no strobe is assigned twice in one step.
  task automatic wr(input etor_byte_t a, input etor_byte_t d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input etor_byte_t a, input etor_byte_t e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    notes.push_back('{"rdata", 0, e});
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask : rd

  // Write, then read the same byte at the very next edge; the port takes them back to back.
  task automatic wr_rd(input etor_byte_t a, input etor_byte_t d, input etor_byte_t e);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    notes.push_back('{"rdata", 0, e});
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask : wr_rd

  // Inputs set before this call are sampled at the next edge; result shows after it.
  task automatic look(input string nm, input int unsigned w, input etor_byte_t e);
    @(posedge ref_clk);
    look_req <= 1'b1;
    notes.push_back('{nm, w, e});
    @(posedge ref_clk);
    look_req <= 1'b0;
  endtask : look

  task automatic test_done();
    if (notes.size() != 0) n_fail++;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////////
  // Watcher: results are settled half a cycle after the edge that produced them.
  always @(posedge ref_clk) begin
    result_due <= (reg_rd & ~srst) | look_req;
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      test_done();
    end
  end

  always @(negedge ref_clk) begin
    etor_note_s nt;
    etor_byte_t got;
    if (result_due) begin
      checked++;
      if (notes.size() == 0) begin
        n_fail++;
        $display("BAD queue expected note seen none");
      end else begin
        nt  = notes.pop_front();
        got = obs(nt.what);
        if (got !== nt.exp) begin
          n_fail++;
          $display("BAD %s expected %h seen %h", nt.name, nt.exp, got);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; the bench plays the test software, the only user this bank should see.
  initial begin
    etor_byte_t d, f, r;
    etor_byte_t sh[4];
    int         i;
    srst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    look_req = 1'b0;
    pll_start_req = 1'b0;
    timer_cal_busy = 1'b0;
    {osc_reg_normal, pll_reg_normal, amp_reg_normal} = 3'h0;
    {osc_ready_raw, pll_ready_raw, amp_ready_raw, pll_lock_raw, crystal_ready_raw} = 5'h00;
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    void'($urandom(4315));
    for (i = 0; i < 4; i++) rd(8'h34 + 8'(i), 8'h00);
    for (i = 1; i < 7; i++) look("reset outputs", i, 8'h00);
    $display("test reset_values done");
    // Random bytes; the calibration register keeps only its low nibble.
    for (i = 0; i < 12; i++) begin
      d = 8'($urandom);
      sh[i % 4] = (i % 4 == 0) ? (d & 8'h0f) : d;
      wr(8'h34 + 8'(i % 4), d);
      rd(8'h34 + 8'(i % 4), sh[i % 4]);
    end
    wr(8'h33, 8'hff);
    wr(8'h38, 8'hff);
    rd(8'h38, 8'h00);
    for (i = 0; i < 4; i++) rd(8'h34 + 8'(i), sh[i]);
    look("cal outputs", 4, sh[0] & 8'h0a);
    look("digital probes", 5, sh[1]);
    look("analog probes", 6, sh[2]);
    // Back to back: the cal byte drops its unused nibble, then the low supply bit is set.
    wr_rd(8'h34, 8'hf5, 8'h05);
    wr_rd(8'h36, 8'h81, 8'h81);
    look("low supply probe", 6, 8'h81);
    $display("test readback_fields done");
    // Every mode, test-bit and normal-line combination of the three regulators.
    for (int m = 0; m < 2; m++) begin
      wr(8'h34, 8'(m << 2));
      for (int fi = 0; fi < 8; fi++) begin
        wr(8'h37, 8'(fi << 5));
        for (int ni = 0; ni < 8; ni++) begin
          {osc_reg_normal, pll_reg_normal, amp_reg_normal} <= 3'(ni);
          look("regulator enables", 1, (m == 1) ? 8'(fi) : 8'(fi | ni));
        end
      end
    end
    $display("test regulator_override done");
    for (i = 0; i < 16; i++) begin
      f = 8'($urandom) & 8'h1f;
      r = 8'($urandom) & 8'h1f;
      wr(8'h37, f);
      {osc_ready_raw, pll_ready_raw, amp_ready_raw, pll_lock_raw, crystal_ready_raw} <= r[4:0];
      look("ready status", 2, f | r);
    end
    $display("test status_force done");
    for (i = 0; i < 8; i++) begin
      wr(8'h34, {7'h00, i[2]});
      pll_start_req  <= i[1];
      timer_cal_busy <= i[0];
      look("pll start", 3, {7'h00, i[1] & ~(i[2] & i[0])});
    end
    // Calibration ends with the request still pending, so the held start now goes.
    timer_cal_busy <= 1'b0;
    look("pll start", 3, 8'h01);
    $display("test pll_hold done");
    // A reset in mid-run must clear what was written.
    wr(8'h35, 8'h5a);
    @(posedge ref_clk);
    srst <= 1'b1;
    @(posedge ref_clk);
    srst <= 1'b0;
    rd(8'h35, 8'h00);
    look("digital probes", 5, 8'h00);
    $display("test midrun_reset done");
    repeat (3) @(posedge ref_clk);
    test_done();
  end

endmodule : etor_regs_tb

`default_nettype wire
